// File: hw/pmt_timer.sv
// Function
// - postscaler divides matches by select plus one
// - reset loads period with all ones
// - count resets to zero, always read/writable
// - control bit 7 reads zero, reset zero
// - prescaler divides by 1, 4 or 16
// - match restarts count and steps postscaler; postscaler output sets flag
// - counts only while run bit set
// - count/control writes clear prescaler and postscaler
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
`include "pmt_consts.svh"

module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`PMT_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`PMT_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        irq
);

  pmt_state_t st;
  pmt_state_t next_st;

  logic                  run;
  logic [3:0]            post_sel;
  logic [`PMT_DIV_W-1:0] pre_last;
  logic                  instr_tick;
  logic                  pre_carry;
  logic                  post_step;
  logic                  post_carry;
  logic                  match;
  logic                  tmr_clear;
  logic                  do_write;
  logic                  wen;
  logic                  wr_control;
  logic                  wr_period;
  logic                  wr_count;
  logic                  wr_flag;
  logic                  wr_enable;
  logic                  wr_mapped;
  logic [7:0]            wbyte;
  logic [7:0]            rd_mux;
  logic                  rd_mapped;

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  assign run      = st.control[`PMT_CTL_RUN_BIT];
  assign post_sel = st.control[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB];

  // prescale code to terminal count; both upper codes give 1:16
  always_comb begin
    case (st.control[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB])
      `PMT_PRE_SEL_1: pre_last = `PMT_PRE_LAST_1;
      `PMT_PRE_SEL_4: pre_last = `PMT_PRE_LAST_4;
      default:        pre_last = `PMT_PRE_LAST_16;
    endcase
  end

  // ----------------------------------------
  // register write decode
  // ----------------------------------------
  // a write lands only once both address and data are held
  assign do_write   = (st.wr_state == PMT_WR_IDLE) && st.aw_got && st.w_got;
  assign wen        = do_write && st.w_strb[0];
  assign wbyte      = st.w_data[7:0];
  assign wr_control = wen && (st.aw_addr == `PMT_OFS_CONTROL);
  assign wr_period  = wen && (st.aw_addr == `PMT_OFS_PERIOD);
  assign wr_count   = wen && (st.aw_addr == `PMT_OFS_COUNT);
  assign wr_flag    = wen && (st.aw_addr == `PMT_OFS_FLAG);
  assign wr_enable  = wen && (st.aw_addr == `PMT_OFS_ENABLE);

  // mapped check ignores strobes so a zero-strobe write still answers okay
  assign wr_mapped  = (st.aw_addr == `PMT_OFS_CONTROL) ||
                      (st.aw_addr == `PMT_OFS_PERIOD)  ||
                      (st.aw_addr == `PMT_OFS_COUNT)   ||
                      (st.aw_addr == `PMT_OFS_FLAG)    ||
                      (st.aw_addr == `PMT_OFS_ENABLE);

  // any count or control write restarts both scalers
  assign tmr_clear  = wr_control || wr_count;

  // ----------------------------------------
  // clock chain: instruction clock, prescaler, postscaler
  // ----------------------------------------
  // instruction clock is aclk divided by four, free running
  pmt_divider u_instr_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .step    (1'b1),
    .last    (`PMT_INSTR_LAST),
    .carry   (instr_tick)
  );

  // prescaler steps only on instruction ticks while running
  pmt_divider u_pre_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (tmr_clear),
    .step    (instr_tick && run),
    .last    (pre_last),
    .carry   (pre_carry)
  );

  assign match     = (st.count == st.period);
  assign post_step = pre_carry && match;

  // postscaler counts matches; select n gives 1:(n+1)
  pmt_divider u_post_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (tmr_clear),
    .step    (post_step),
    .last    (post_sel),
    .carry   (post_carry)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_mux    = 8'h00;
    rd_mapped = 1'b1;
    case (araddr)
      `PMT_OFS_CONTROL: rd_mux = st.control & `PMT_CTL_WMASK;
      `PMT_OFS_PERIOD:  rd_mux = st.period;
      `PMT_OFS_COUNT:   rd_mux = st.count;
      `PMT_OFS_FLAG:    rd_mux[`PMT_MATCH_BIT] = st.match_flag;
      `PMT_OFS_ENABLE:  rd_mux[`PMT_MATCH_BIT] = st.match_irq_enable;
      default:          rd_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // write address and data are taken independently
    if (awvalid && awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end

    // perform write and raise the response
    if (do_write) begin
      next_st.aw_got   = 1'b0;
      next_st.w_got    = 1'b0;
      next_st.wr_state = PMT_WR_RESP;
      next_st.bresp    = wr_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end
    if ((st.wr_state == PMT_WR_RESP) && bready) begin
      next_st.wr_state = PMT_WR_IDLE;
    end

    // read data is captured in the cycle the address is taken and answered the cycle after
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h00_0000, rd_mux};
      next_st.rresp  = rd_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end

    // count advances on prescaler output, restarts after a match
    if (pre_carry) begin
      next_st.count = match ? `PMT_COUNT_RST : st.count + 8'h01;
    end

    // software writes win over a same-cycle increment
    if (wr_count) begin
      next_st.count = wbyte;
    end
    if (wr_control) begin
      next_st.control = wbyte & `PMT_CTL_WMASK;
    end
    if (wr_period) begin
      next_st.period = wbyte;
    end
    if (wr_enable) begin
      next_st.match_irq_enable = wbyte[`PMT_MATCH_BIT];
    end

    // flag clears by writing one; a same-cycle event wins
    if (wr_flag && wbyte[`PMT_MATCH_BIT]) begin
      next_st.match_flag = 1'b0;
    end
    if (post_carry) begin
      next_st.match_flag = 1'b1;
    end

    // shadow counts watched only by the checks below
    if (tmr_clear || pre_carry) begin
      next_st.chk_pre = 4'h0;
    end else if (instr_tick && run) begin
      next_st.chk_pre = st.chk_pre + 4'h1;
    end
    if (tmr_clear || post_carry) begin
      next_st.chk_post = 4'h0;
    end else if (post_step) begin
      next_st.chk_post = st.chk_post + 4'h1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.control <= `PMT_CONTROL_RST;
      st.period  <= `PMT_PERIOD_RST;
      st.count   <= `PMT_COUNT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // single address slot per channel, so ready falls while one is held
  assign awready = !st.aw_got;
  assign wready  = !st.w_got;
  assign bvalid  = (st.wr_state == PMT_WR_RESP);
  assign bresp   = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;

  // level interrupt while the sticky flag is set and enabled
  assign irq     = st.match_flag && st.match_irq_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  sequence s_match_step;
    pre_carry && match && !tmr_clear;
  endsequence

  sequence s_count_zero;
    st.count == `PMT_COUNT_RST;
  endsequence

  sequence s_both_held;
    st.aw_got && st.w_got && (st.wr_state == PMT_WR_IDLE);
  endsequence

  a_post_ratio:
    assert property (post_carry |-> (st.chk_post == post_sel))
    else $error("postscaler fired at wrong match count");

  a_period_reset:
    assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> (st.period == `PMT_PERIOD_RST))
    else $error("period not all ones after reset");

  a_count_reset:
    assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> s_count_zero and (st.control == `PMT_CONTROL_RST))
    else $error("count or control not zero after reset");

  a_count_write:
    assert property (wr_count |=> (st.count == $past(wbyte)))
    else $error("count write not stored");

  a_ctl_top_bit:
    assert property ((arvalid && arready && (araddr == `PMT_OFS_CONTROL))
      |=> rvalid && (rdata[31:7] == 25'h000_0000))
    else $error("control bit 7 read back nonzero");

  a_pre_ratio:
    assert property (pre_carry |-> (st.chk_pre ==
      (st.control[1] ? 4'hf : (st.control[0] ? 4'h3 : 4'h0))))
    else $error("prescaler fired at wrong tick count");

  a_match_restart:
    assert property (s_match_step |=> s_count_zero)
    else $error("count did not restart after match");

  a_flag_set:
    assert property (post_carry |=> st.match_flag ##1 st.match_flag ||
      $past(wr_flag))
    else $error("postscaler output did not set flag");

  a_stop_hold:
    assert property ((!run && !wr_count) |=> (st.count == $past(st.count)))
    else $error("count moved while stopped");

  a_ctl_keeps:
    assert property (wr_control |=> (st.count == $past(st.count)) &&
      (st.chk_pre == 4'h0) && (st.chk_post == 4'h0))
    else $error("control write disturbed count or kept scalers");

  a_flag_sticky:
    assert property ((st.match_flag && !(wr_flag && wbyte[`PMT_MATCH_BIT]))
      |=> st.match_flag)
    else $error("flag dropped without software clear");

  a_irq_gate:
    assert property ((post_carry && st.match_irq_enable && !wr_enable)
      |=> irq)
    else $error("enabled match did not raise interrupt");

  a_write_answer:
    assert property (s_both_held |=> bvalid)
    else $error("write not answered one cycle after both held");

endmodule : pmt_timer

`default_nettype wire

// File: common/pmt_consts.svh
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define PMT_ADDR_W       8
`define PMT_OFS_CONTROL  8'h00
`define PMT_OFS_PERIOD   8'h04
`define PMT_OFS_COUNT    8'h08
`define PMT_OFS_FLAG     8'h0c
`define PMT_OFS_ENABLE   8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define PMT_CTL_POST_MSB 6
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_RUN_BIT  2
`define PMT_CTL_PRE_MSB  1
`define PMT_CTL_PRE_LSB  0
`define PMT_CTL_WMASK    8'h7f
`define PMT_MATCH_BIT    1

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMT_CONTROL_RST  8'h00
`define PMT_PERIOD_RST   8'hff
`define PMT_COUNT_RST    8'h00

// ----------------------------------------
// divider terminal counts (ratio minus one)
// ----------------------------------------
`define PMT_DIV_W        4
`define PMT_INSTR_LAST   4'h3
`define PMT_PRE_LAST_1   4'h0
`define PMT_PRE_LAST_4   4'h3
`define PMT_PRE_LAST_16  4'hf
`define PMT_PRE_SEL_1    2'b00
`define PMT_PRE_SEL_4    2'b01

// ----------------------------------------
// bus responses
// ----------------------------------------
`define PMT_RESP_OKAY    2'b00
`define PMT_RESP_SLVERR  2'b10

`endif

// File: common/pmt_pkg.sv
`default_nettype none
`include "pmt_consts.svh"

package pmt_pkg;

  // write response phase
  typedef enum logic [0:0] {
    PMT_WR_IDLE = 1'b0,
    PMT_WR_RESP = 1'b1
  } pmt_wr_state_t;

  // divider state
  typedef struct packed {
    logic [`PMT_DIV_W-1:0] cnt;
  } pmt_div_state_t;

  // whole state of the timer top
  typedef struct packed {
    logic [7:0]            control;
    logic [7:0]            period;
    logic [7:0]            count;
    logic                  match_flag;
    logic                  match_irq_enable;
    logic                  aw_got;
    logic [`PMT_ADDR_W-1:0] aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    pmt_wr_state_t         wr_state;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [3:0]            chk_pre;
    logic [3:0]            chk_post;
  } pmt_state_t;

endpackage : pmt_pkg

`default_nettype wire

// File: hw/pmt_divider.sv
`default_nettype none
`include "pmt_consts.svh"

module pmt_divider
  import pmt_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clear,
  input  wire logic                  step,
  input  wire logic [`PMT_DIV_W-1:0] last,
  output logic                       carry
);

  pmt_div_state_t st;
  pmt_div_state_t next_st;

  // ----------------------------------------
  // carry and next count
  // ----------------------------------------
  // a ratio lowered below the count wraps on the next step, never stalls
  assign carry = step && !clear && (st.cnt >= last);

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.cnt = '0;
    end else if (carry) begin
      next_st.cnt = '0;
    end else if (step) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : pmt_divider

`default_nettype wire

// File: testbench/pmt_timer_test.sv
`default_nettype none
`include "pmt_consts.svh"

module pmt_timer_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // settings and signals
  // ----------------------------------------
  localparam int         LIMIT = 80000;
  localparam int         PER   = 3;
  localparam logic [7:0] MBIT  = 8'h01 << `PMT_MATCH_BIT;
  localparam logic [1:0] OK    = `PMT_RESP_OKAY;
  localparam logic [1:0] ERR   = `PMT_RESP_SLVERR;

  logic                   aclk;
  logic                   aresetn;
  logic                   awvalid;
  logic                   awready;
  logic [`PMT_ADDR_W-1:0] awaddr;
  logic                   wvalid;
  logic                   wready;
  logic [31:0]            wdata;
  logic                   bvalid;
  logic [1:0]             bresp;
  logic                   arvalid;
  logic                   arready;
  logic [`PMT_ADDR_W-1:0] araddr;
  logic                   rvalid;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   irq;
  logic [31:0]            v;
  int                     miscompares;
  int                     n_compared;
  int                     cyc;

  // bready/rready held high: the master is always willing to take answers
  pmt_timer uut (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .awprot  (3'b000),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (4'hf),
    .bvalid  (bvalid),
    .bready  (1'b1),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .arprot  (3'b000),
    .rvalid  (rvalid),
    .rready  (1'b1),
    .rdata   (rdata),
    .rresp   (rresp),
    .irq     (irq)
  );

  // 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // cycle count, also cuts a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      $display("[FAIL] %0t run timed out", $time);
      print_verdict();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // aw and w offered together, each dropped once taken
  // no local limit: a missing answer is caught by the run timeout
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    check({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : rd

  task rdc(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    rd(a, er, d);
    check(d, {24'h00_0000, exp}, "read data");
  endtask : rdc

  // sampled at edges, so two calls give an exact cycle distance
  task wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (irq !== 1'b1 && n < 10000);
    t = cyc;
    check({31'h0, irq}, 32'h0000_0001, "irq raised");
  endtask : wait_irq

  // first set after the control write is partial, so time from it to the next set, one full interval
  task measure(input logic [1:0] pre, input logic [3:0] post);
    int t1;
    int t2;
    int ratio;
    ratio = (pre == 2'b00) ? 1 : (pre == 2'b01) ? 4 : 16;
    wr(`PMT_OFS_CONTROL, {1'b0, post, 1'b1, pre}, OK);
    wr(`PMT_OFS_FLAG, MBIT, OK);
    wait_irq(t1);
    wr(`PMT_OFS_FLAG, MBIT, OK);
    wait_irq(t2);
    check(t2 - t1, 4 * ratio * (PER + 1) * (post + 1), "match interval");
  endtask : measure

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn     = 1'b0;
    awvalid     = 1'b0;
    wvalid      = 1'b0;
    arvalid     = 1'b0;
    awaddr      = '0;
    araddr      = '0;
    wdata       = '0;
    cyc         = 0;
    miscompares = 0;
    n_compared  = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values
    rdc(`PMT_OFS_CONTROL, 8'h00, OK);
    rdc(`PMT_OFS_PERIOD, 8'hff, OK);
    rdc(`PMT_OFS_COUNT, 8'h00, OK);
    rdc(`PMT_OFS_FLAG, 8'h00, OK);
    rdc(`PMT_OFS_ENABLE, 8'h00, OK);
    // unmapped place answers with an error and no data
    wr(8'h14, 8'hff, ERR);
    rdc(8'h14, 8'h00, ERR);
    // top control bit never reads back
    wr(`PMT_OFS_CONTROL, 8'hfb, OK);
    rdc(`PMT_OFS_CONTROL, 8'h7b, OK);
    // stopped timer holds its count; control write leaves it alone
    wr(`PMT_OFS_COUNT, 8'h40, OK);
    repeat (100) @(posedge aclk);
    rdc(`PMT_OFS_COUNT, 8'h40, OK);
    wr(`PMT_OFS_CONTROL, 8'h29, OK);
    rdc(`PMT_OFS_COUNT, 8'h40, OK);
    rdc(`PMT_OFS_CONTROL, 8'h29, OK);
    // running 1:1 counts one per four cycles, tick phase unknown
    wr(`PMT_OFS_CONTROL, 8'h04, OK);
    wr(`PMT_OFS_COUNT, 8'h00, OK);
    repeat (40) @(posedge aclk);
    rd(`PMT_OFS_COUNT, OK, v);
    check({31'h0, v >= 9 && v <= 12}, 32'h0000_0001, "count rate");
    // masked: flag sets and sticks, no interrupt
    wr(`PMT_OFS_PERIOD, PER[7:0], OK);
    // count is already past the new period; restart it or it wraps first
    wr(`PMT_OFS_COUNT, 8'h00, OK);
    repeat (200) @(posedge aclk);
    wr(`PMT_OFS_CONTROL, 8'h00, OK);
    rdc(`PMT_OFS_FLAG, MBIT, OK);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    repeat (50) @(posedge aclk);
    rdc(`PMT_OFS_FLAG, MBIT, OK);
    wr(`PMT_OFS_FLAG, MBIT, OK);
    rdc(`PMT_OFS_FLAG, 8'h00, OK);
    wr(`PMT_OFS_ENABLE, MBIT, OK);
    rdc(`PMT_OFS_ENABLE, MBIT, OK);
    // every postscale code at 1:1, both ends at the other prescales
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 16; s++) begin
        if (p == 0 || s == 0 || s == 15) measure(p[1:0], s[3:0]);
      end
    end
    print_verdict();
  end

endmodule : pmt_timer_test

`default_nettype wire
